// ==== rtl/shp_pkg.sv ====
package shp_pkg;

   // ************************************************************
   // Serial frame layout
   // ************************************************************
   // A frame is one command byte then one data byte, MSB first.
   localparam logic [3:0] CNT_CMD_LAST = 4'h7;
   localparam logic [3:0] CNT_FRAME_LAST = 4'hF;
   localparam int unsigned CMD_RW_BIT = 7;
   localparam logic [3:0] CMD_PAGE_ZERO = 4'h0;

   // ************************************************************
   // Serial register map
   // ************************************************************
   localparam int unsigned NUM_CTRL = 7;
   localparam logic [2:0] SREG_MASK = 3'h6;
   localparam logic [2:0] SREG_STATUS = 3'h7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ************************************************************
   // Avalon-MM register map, byte addresses
   // ************************************************************
   localparam logic [4:0] AVL_STRAP = 5'h00;
   localparam logic [4:0] AVL_CFG = 5'h04;
   localparam logic [4:0] AVL_CTRL_A = 5'h08;
   localparam logic [4:0] AVL_CTRL_B = 5'h0C;

   // Field positions of the strap register.
   localparam int unsigned STRAP_SEL_LO = 0;
   localparam int unsigned STRAP_SEL_HI = 1;
   localparam int unsigned STRAP_BUS_TYPE = 2;
   localparam int unsigned STRAP_SERIAL = 3;
   localparam int unsigned STRAP_FAULT = 4;
   localparam int unsigned STRAP_INT_PIN = 5;
   localparam int unsigned STRAP_HW_RST = 6;
   localparam int unsigned STRAP_IN_EDGE = 7;
   localparam int unsigned STRAP_OUT_EDGE = 8;

   // Configuration register field and reset value.
   localparam int unsigned CFG_PORT_EN = 0;
   localparam logic CFG_PORT_EN_RESET = 1'b1;

   // Reset image of the synchronised pins, idle levels: chip select
   // high and serial clock low, so no false edge follows reset.
   localparam logic [9:0] PIN_RESET = 10'h221;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CMD,
      ST_DATA,
      ST_HOLD
   } shp_state_t;

endpackage

// ==== rtl/shp_sync.sv ====
`timescale 1ns/100ps
module shp_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Two flops per pin; only the second stage leaves this module.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= RST;
         sync_q <= RST;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

// ==== rtl/shp_edge.sv ====
`timescale 1ns/100ps
module shp_edge (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic sclk_s_i,
   input wire logic in_edge_sel_i,
   input wire logic out_edge_sel_i,
   output logic rise_o,
   output logic fall_o,
   output logic samp_o,
   output logic launch_o,
   output logic cap_o
);

   logic prev_q;
   logic prev_d;

   // Previous level of the already synchronised serial clock.
   always_comb begin
      prev_d = sclk_s_i;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // Edges are one-cycle strobes on the system clock.
   assign rise_o = sclk_s_i & ~prev_q;
   assign fall_o = ~sclk_s_i & prev_q;
   assign samp_o = in_edge_sel_i ? fall_o : rise_o;
   // The host captures on the opposite edge, so change on this one.
   assign cap_o = out_edge_sel_i ? rise_o : fall_o;
   assign launch_o = out_edge_sel_i ? fall_o : rise_o;

endmodule

// ==== rtl/shp_serial_port.sv ====
`timescale 1ns/100ps
module shp_serial_port (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic iface_select_lo_i,
   input wire logic iface_select_hi_i,
   input wire logic bus_type_sel_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic ser_in_i,
   input wire logic in_edge_sel_i,
   input wire logic out_edge_sel_i,
   input wire logic hw_reset_n_i,
   output logic ser_out_o,
   output logic ser_out_oe_n_o,
   input wire logic int_n_i,
   output logic int_n_o,
   output logic int_n_oe_n_o,
   input wire logic [7:0] cond_evt_i,
   output logic [55:0] ctrl_bits_o
);

   // ************************************************************
   // Pin synchronisers and serial clock edges
   // ************************************************************
   logic [9:0] pins_s;
   logic sel_lo_s, sel_hi_s, bus_type_s, cs_n_s, sclk_s, ser_in_s;
   logic in_sel_s, out_sel_s, hw_rst_n_s, int_pin_s;
   logic sclk_rise, sclk_fall, samp, launch, cap;

   shp_sync #(
      .W(10),
      .RST(shp_pkg::PIN_RESET)
   ) u_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .async_i({int_n_i, iface_select_lo_i, iface_select_hi_i,
                bus_type_sel_i, cs_n_i, sclk_i, ser_in_i,
                in_edge_sel_i, out_edge_sel_i, hw_reset_n_i}),
      .sync_o(pins_s)
   );

   // Straps and link pins all share the same two-flop delay.
   assign {int_pin_s, sel_lo_s, sel_hi_s, bus_type_s, cs_n_s, sclk_s,
           ser_in_s, in_sel_s, out_sel_s, hw_rst_n_s} = pins_s;

   // Only host clock edges pace the shifter.
   shp_edge u_edge (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .sclk_s_i(sclk_s),
      .in_edge_sel_i(in_sel_s),
      .out_edge_sel_i(out_sel_s),
      .rise_o(sclk_rise),
      .fall_o(sclk_fall),
      .samp_o(samp),
      .launch_o(launch),
      .cap_o(cap)
   );

   // ************************************************************
   // Mode selection
   // ************************************************************
   logic serial_mode;
   logic port_en_q, port_en_d;
   logic cs_act;

   // Serial mode needs select bit one high and bit zero low.
   assign serial_mode = sel_hi_s & ~sel_lo_s;
   // A frame lives only while chip select is low in serial mode.
   assign cs_act = ~cs_n_s & serial_mode & port_en_q & hw_rst_n_s;

   // ************************************************************
   // Serial frame engine
   // ************************************************************
   shp_pkg::shp_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] in_sr_q, in_sr_d;
   logic [7:0] cmd_q, cmd_d;
   logic [7:0] out_sr_q, out_sr_d;
   logic cap_seen_q, cap_seen_d;
   logic oe_n_q, oe_n_d;
   logic wr_stb, rd_ld;
   logic [7:0] wr_data;
   logic [7:0] shifted;
   logic [7:0] rd_val;
   logic [7:0] ctrl_q [shp_pkg::NUM_CTRL];
   logic [7:0] stat_q, stat_d;

   assign shifted = {in_sr_q[6:0], ser_in_s};

   // Address page must be zero; upper pages read as zero.
   always_comb begin
      rd_val = 8'h00;
      if (shifted[6:3] == shp_pkg::CMD_PAGE_ZERO) begin
         if (shifted[2:0] == shp_pkg::SREG_STATUS) begin
            rd_val = stat_q;
         end else begin
            rd_val = ctrl_q[shifted[2:0]];
         end
      end
   end

   // Next state of the shifter; any chip select release aborts.
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      in_sr_d = in_sr_q;
      cmd_d = cmd_q;
      out_sr_d = out_sr_q;
      cap_seen_d = cap_seen_q;
      wr_stb = 1'b0;
      rd_ld = 1'b0;
      wr_data = shifted;
      if (!cs_act) begin
         st_d = shp_pkg::ST_IDLE;
         cnt_d = 4'h0;
         cap_seen_d = 1'b0;
      end else begin
         case (st_q)
            shp_pkg::ST_IDLE: begin
               st_d = shp_pkg::ST_CMD;
               cnt_d = 4'h0;
            end
            shp_pkg::ST_CMD: begin
               if (samp) begin
                  in_sr_d = shifted;
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == shp_pkg::CNT_CMD_LAST) begin
                     cmd_d = shifted;
                     st_d = shp_pkg::ST_DATA;
                     cap_seen_d = 1'b0;
                     if (shifted[shp_pkg::CMD_RW_BIT]) begin
                        out_sr_d = rd_val;
                        rd_ld = 1'b1;
                     end
                  end
               end
            end
            shp_pkg::ST_DATA: begin
               if (samp) begin
                  in_sr_d = shifted;
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == shp_pkg::CNT_FRAME_LAST) begin
                     st_d = shp_pkg::ST_HOLD;
                     wr_stb = ~cmd_q[shp_pkg::CMD_RW_BIT];
                  end
               end
               // Shift only after the host has captured the bit.
               if (cap) begin
                  cap_seen_d = 1'b1;
               end else if (launch && cap_seen_q) begin
                  out_sr_d = {out_sr_q[6:0], 1'b0};
                  cap_seen_d = 1'b0;
               end
            end
            default: begin
               st_d = shp_pkg::ST_HOLD;
            end
         endcase
      end
      oe_n_d = ~((st_d == shp_pkg::ST_DATA) & cmd_d[shp_pkg::CMD_RW_BIT]);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= shp_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         in_sr_q <= 8'h00;
         cmd_q <= 8'h00;
         out_sr_q <= 8'h00;
         cap_seen_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         in_sr_q <= in_sr_d;
         cmd_q <= cmd_d;
         out_sr_q <= out_sr_d;
         cap_seen_q <= cap_seen_d;
         oe_n_q <= oe_n_d;
      end
   end

   // The pin only drives while a read frame is in its data byte.
   assign ser_out_o = out_sr_q[7];
   assign ser_out_oe_n_o = oe_n_q;

   // ************************************************************
   // Control and status registers
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < shp_pkg::NUM_CTRL; gi = gi + 1) begin : g_ctrl
         logic [7:0] nxt;
         // Hardware reset is a level: held low keeps bits clear.
         always_comb begin
            nxt = ctrl_q[gi];
            if (!hw_rst_n_s) begin
               nxt = shp_pkg::CTRL_RESET;
            end else if (wr_stb && cmd_q[6:3] == shp_pkg::CMD_PAGE_ZERO
                         && cmd_q[2:0] == 3'(gi)) begin
               nxt = wr_data;
            end
         end
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               ctrl_q[gi] <= shp_pkg::CTRL_RESET;
            end else begin
               ctrl_q[gi] <= nxt;
            end
         end
         assign ctrl_bits_o[gi*8 +: 8] = ctrl_q[gi];
      end
   endgenerate

   // Status bits are write-one-to-clear; a new event wins the clear.
   always_comb begin
      stat_d = stat_q;
      if (wr_stb && cmd_q[6:3] == shp_pkg::CMD_PAGE_ZERO
          && cmd_q[2:0] == shp_pkg::SREG_STATUS) begin
         stat_d = stat_q & ~wr_data;
      end
      stat_d = stat_d | cond_evt_i;
   end

   // ************************************************************
   // Open-drain interrupt
   // ************************************************************
   logic int_oe_n_q, int_oe_n_d;

   // Pull low while any unmasked status bit stands.
   always_comb begin
      int_oe_n_d = ~|(stat_q & ctrl_q[shp_pkg::SREG_MASK]);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stat_q <= shp_pkg::STATUS_RESET;
         int_oe_n_q <= 1'b1;
      end else begin
         stat_q <= stat_d;
         int_oe_n_q <= int_oe_n_d;
      end
   end

   assign int_n_o = 1'b0;
   assign int_n_oe_n_o = int_oe_n_q;

   // ************************************************************
   // Avalon-MM slave
   // ************************************************************
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic fault_q, fault_d;
   logic [8:0] strap_view;

   assign strap_view = {out_sel_s, in_sel_s, ~hw_rst_n_s, int_pin_s,
                        fault_q, serial_mode, bus_type_s, sel_hi_s,
                        sel_lo_s};

   // Every access waits exactly one cycle, so read data comes from flops.
   always_comb begin
      ack_d = (avs_read_i | avs_write_i) & ~ack_q;
      rdata_d = rdata_q;
      port_en_d = port_en_q;
      fault_d = serial_mode & bus_type_s;
      if (avs_read_i && !ack_q) begin
         if (avs_address_i == shp_pkg::AVL_STRAP) begin
            rdata_d = {23'h000000, strap_view};
         end else if (avs_address_i == shp_pkg::AVL_CFG) begin
            rdata_d = {31'h00000000, port_en_q};
         end else if (avs_address_i == shp_pkg::AVL_CTRL_A) begin
            rdata_d = {ctrl_q[3], ctrl_q[2], ctrl_q[1], ctrl_q[0]};
         end else if (avs_address_i == shp_pkg::AVL_CTRL_B) begin
            rdata_d = {stat_q, ctrl_q[6], ctrl_q[5], ctrl_q[4]};
         end else begin
            rdata_d = 32'h00000000;
         end
      end
      if (avs_write_i && ack_q && avs_address_i == shp_pkg::AVL_CFG
          && avs_byteenable_i[0]) begin
         port_en_d = avs_writedata_i[shp_pkg::CFG_PORT_EN];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
         port_en_q <= shp_pkg::CFG_PORT_EN_RESET;
         fault_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         port_en_q <= port_en_d;
         fault_q <= fault_d;
      end
   end

   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
   assign avs_readdata_o = rdata_q;

   // ************************************************************
   // Checks
   // ************************************************************
   logic samp_want, launch_want;
   assign samp_want = in_sel_s ? sclk_fall : sclk_rise;
   assign launch_want = out_sel_s ? sclk_fall : sclk_rise;

   chk_par_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !sel_hi_s |=> st_q == shp_pkg::ST_IDLE)
      else $error("Serial engine active in parallel mode.");
   chk_cs_noacc: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cs_n_s && hw_rst_n_s |=> $stable(ctrl_bits_o))
      else $error("Control changed with chip select high.");
   chk_samp_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (cnt_q != $past(cnt_q)) && (cnt_q != 4'h0) |-> $past(samp_want))
      else $error("Input bit taken on the wrong edge.");
   chk_out_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $changed(out_sr_q) && !$past(rd_ld) |-> $past(launch_want))
      else $error("Output bit moved on the wrong edge.");
   chk_int_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (|(stat_q & ctrl_q[shp_pkg::SREG_MASK])) |=> !int_n_oe_n_o)
      else $error("Interrupt not pulled low.");
   chk_int_free: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !(|(stat_q & ctrl_q[shp_pkg::SREG_MASK])) |=> int_n_oe_n_o)
      else $error("Interrupt pulled low with no cause.");
   chk_hwrst_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !hw_rst_n_s |=> ctrl_bits_o == 56'h00000000000000)
      else $error("Control bits survive hardware reset.");
   chk_bitpos_clr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !cs_act |=> cnt_q == 4'h0 && st_q == shp_pkg::ST_IDLE)
      else $error("Bit position kept after chip select release.");
   chk_strap_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      serial_mode && bus_type_s |=> fault_q)
      else $error("Bus type strap fault not flagged.");
   chk_bus_wait: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("Wait request held longer than one cycle.");

endmodule

// ==== testbench/shp_host_model.sv ====
`timescale 1ns/100ps
// ************************************************************
// Host side of the serial control link
// ************************************************************
module shp_host_model (
   input wire logic clk_i,
   input wire logic in_edge_sel_i,
   input wire logic out_edge_sel_i,
   input wire logic ser_line_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic ser_in_o
);
   // Link idles deselected with the clock standing low.
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      ser_in_o = 1'b0;
   end

   // One frame of nb bits; hp is the half period in system clocks.
   // A short nb aborts the frame by raising chip select early.
   task automatic frame(input logic [15:0] bits, input int nb,
                        input int hp, output logic [7:0] rd);
      int ns;
      int nc;
      logic s_rise;
      logic c_rise;
      ns = 0;
      nc = 0;
      rd = 8'h00;
      s_rise = ~in_edge_sel_i;
      c_rise = out_edge_sel_i;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      for (int e = 0; e < 2 * nb; e++) begin
         // Data is set a half period ahead of its sampling edge.
         if (((e % 2) == 0) == s_rise) begin
            ser_in_o <= bits[15 - ns];
         end
         repeat (hp) @(posedge clk_i);
         if (((e % 2) == 0) == c_rise && ns >= 8 && nc < 8) begin
            rd = {rd[6:0], ser_line_i};
            nc++;
         end
         sclk_o <= ~sclk_o;
         if (((e % 2) == 0) == s_rise) begin
            ns++;
         end
      end
      repeat (hp) @(posedge clk_i);
      cs_n_o <= 1'b1;
      ser_in_o <= ~ser_in_o;
      repeat (hp) @(posedge clk_i);
   endtask
endmodule

// ==== testbench/serial_host_control_port_tb_top.sv ====
`timescale 1ns/100ps
// ************************************************************
// Bench top with reference model
// ************************************************************
module serial_host_control_port_tb_top;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic wreq;
   logic sel_lo = 1'b0;
   logic sel_hi = 1'b1;
   logic bus_type = 1'b0;
   logic in_edge = 1'b0;
   logic out_edge = 1'b0;
   logic hw_rst_n = 1'b1;
   logic [7:0] cond_evt = 8'h00;
   logic cs_n, sclk, ser_in, ser_out, ser_oe_n, int_o, int_oe_n;
   logic ser_line, int_wire;
   logic [55:0] ctrl_bits;
   int n_mismatch = 0;
   int checks = 0;
   int ref_ctrl[7] = '{default: 0};
   int ref_status = 0;
   logic cfg_en = 1'b1;

   // Clock at 40 MHz.
   always #12.5 clk_i = ~clk_i;

   // Released data line shows the inverse; interrupt wire is pulled up.
   assign ser_line = ser_oe_n ? ~ser_out : ser_out;
   assign int_wire = int_oe_n ? 1'b1 : int_o;

   shp_serial_port u_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .iface_select_lo_i(sel_lo),
      .iface_select_hi_i(sel_hi), .bus_type_sel_i(bus_type),
      .cs_n_i(cs_n), .sclk_i(sclk), .ser_in_i(ser_in),
      .in_edge_sel_i(in_edge), .out_edge_sel_i(out_edge),
      .hw_reset_n_i(hw_rst_n), .ser_out_o(ser_out),
      .ser_out_oe_n_o(ser_oe_n), .int_n_i(int_wire), .int_n_o(int_o),
      .int_n_oe_n_o(int_oe_n), .cond_evt_i(cond_evt),
      .ctrl_bits_o(ctrl_bits)
   );

   shp_host_model u_host (
      .clk_i(clk_i), .in_edge_sel_i(in_edge), .out_edge_sel_i(out_edge),
      .ser_line_i(ser_line), .cs_n_o(cs_n), .sclk_o(sclk),
      .ser_in_o(ser_in)
   );

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Avalon master: hold the request until waitrequest is seen low.
   task automatic avl(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a;
      wdat <= d;
      rd_en <= ~w;
      wr_en <= w;
      @(posedge clk_i);
      while (wreq !== 1'b0 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      q = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask

   function automatic logic [31:0] strap_exp();
      logic s;
      s = sel_hi & ~sel_lo;
      return {23'h0, out_edge, in_edge, ~hw_rst_n,
              logic'((ref_status & ref_ctrl[6]) == 0), bus_type & s, s,
              bus_type, sel_hi, sel_lo};
   endfunction

   task automatic check_ctrl();
      logic [31:0] q;
      for (int i = 0; i < 7; i++) cmp(ctrl_bits[8*i +: 8], ref_ctrl[i]);
      avl(1'b0, shp_pkg::AVL_CTRL_A, 32'h0, q);
      cmp(q, {ref_ctrl[3][7:0], ref_ctrl[2][7:0], ref_ctrl[1][7:0],
              ref_ctrl[0][7:0]});
      avl(1'b0, shp_pkg::AVL_CTRL_B, 32'h0, q);
      cmp(q, {ref_status[7:0], ref_ctrl[6][7:0], ref_ctrl[5][7:0],
              ref_ctrl[4][7:0]});
      avl(1'b0, shp_pkg::AVL_STRAP, 32'h0, q);
      cmp(q, strap_exp());
      cmp(int_wire, (ref_status & ref_ctrl[6]) == 0);
   endtask

   // One serial frame; the model only changes when the port is live.
   task automatic xfer(input logic r_w, input int r, input int d,
                       input int nb);
      logic [7:0] q;
      logic live;
      live = sel_hi && !sel_lo && hw_rst_n && cfg_en && nb == 16;
      // Half period of 4 system clocks gives the 200 ns link clock.
      u_host.frame({r_w, 4'h0, 3'(r), 8'(d)}, nb, 4, q);
      if (live && r_w) cmp(q, r == 7 ? ref_status : ref_ctrl[r]);
      if (live && !r_w && r == 7) ref_status &= ~(d & 255);
      if (live && !r_w && r < 7) ref_ctrl[r] = d & 255;
      repeat (4) @(posedge clk_i);
   endtask

   task automatic pulse_evt(input logic [7:0] e);
      cond_evt <= e;
      @(posedge clk_i);
      cond_evt <= 8'h00;
      ref_status |= e;
      repeat (4) @(posedge clk_i);
   endtask

   // Main sequence.
   initial begin
      logic [31:0] q;
      void'($urandom(20));
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      avl(1'b0, shp_pkg::AVL_CFG, 32'h0, q);
      cmp(q, 32'h1);
      avl(1'b0, 5'h10, 32'h0, q);
      cmp(q, 32'h0);
      check_ctrl();
      // Every edge selection against every control register.
      for (int m = 0; m < 4; m++) begin
         in_edge <= m[0];
         out_edge <= m[1];
         repeat (4) @(posedge clk_i);
         for (int r = 0; r < 7; r++) begin
            xfer(1'b0, r, $urandom_range(255), 16);
            xfer(1'b1, r, 0, 16);
         end
         check_ctrl();
      end
      // Abort mid-frame, then a whole frame must still land.
      xfer(1'b0, 1, 8'h5A, 10);
      check_ctrl();
      xfer(1'b0, 1, 8'hA5, 16);
      check_ctrl();
      // Masked and unmasked events, then clear by write-one.
      xfer(1'b0, 6, 8'h03, 16);
      pulse_evt(8'h80);
      check_ctrl();
      pulse_evt(8'h02);
      check_ctrl();
      xfer(1'b1, 7, 0, 16);
      xfer(1'b0, 7, 8'h02, 16);
      check_ctrl();
      // Hardware reset clears control bits only, writes are dropped.
      hw_rst_n <= 1'b0;
      foreach (ref_ctrl[i]) ref_ctrl[i] = 0;
      repeat (6) @(posedge clk_i);
      xfer(1'b0, 2, 8'h3C, 16);
      check_ctrl();
      hw_rst_n <= 1'b1;
      // Parallel port selected: the serial side stays idle.
      sel_hi <= 1'b0;
      repeat (6) @(posedge clk_i);
      xfer(1'b0, 2, 8'h3C, 16);
      check_ctrl();
      sel_hi <= 1'b1;
      bus_type <= 1'b1;
      repeat (6) @(posedge clk_i);
      xfer(1'b0, 3, 8'hC3, 16);
      check_ctrl();
      bus_type <= 1'b0;
      // Port disabled by software, unmapped write ignored.
      avl(1'b1, shp_pkg::AVL_CFG, 32'h0, q);
      cfg_en = 1'b0;
      avl(1'b0, shp_pkg::AVL_CFG, 32'h0, q);
      cmp(q, 32'h0);
      xfer(1'b0, 4, 8'h77, 16);
      avl(1'b1, 5'h10, 32'hFFFFFFFF, q);
      check_ctrl();
      end_of_test();
   end

   // Run is about 9,500 cycles; a hang is cut well beyond that.
   initial begin
      #2000000;
      n_mismatch++;
      end_of_test();
   end
endmodule
